/* rtl/fifo_pkg.sv */
package fifo_pkg;
   // Data path
   localparam int DATA_W = 72;
   localparam int DEPTH = 16;
   localparam int PTR_W = 4;
   localparam int CNT_W = 5;
   localparam int OFFSET_W = 5;
   // Output width straps
   localparam logic [1:0] WIDTH_72 = 2'h0;
   localparam logic [1:0] WIDTH_36 = 2'h1;
   localparam logic [1:0] WIDTH_18 = 2'h2;
   localparam int LANE_36 = 36;
   localparam int LANE_18 = 18;
   // Offset defaults after master reset
   localparam logic [OFFSET_W-1:0] EMPTY_OFFSET_RST = 5'h02;
   localparam logic [OFFSET_W-1:0] FULL_OFFSET_RST = 5'h02;
   localparam logic [CNT_W-1:0] DEPTH_CNT = 5'h10;
   // Synchronised pin vector positions
   localparam int S_RCLK = 0;
   localparam int S_REN_N = 1;
   localparam int S_RCS_N = 2;
   localparam int S_OE_N = 3;
   localparam int S_RT_N = 4;
   localparam int S_MARK = 5;
   localparam int S_LD_N = 6;
   localparam int S_SCLK = 7;
   localparam int S_SEN_N = 8;
   localparam int S_SI = 9;
   localparam int S_MRS_N = 10;
   localparam int S_PRS_N = 11;
   localparam int S_PFM = 12;
   localparam int S_ASYNC = 13;
   localparam int S_OW0 = 14;
   localparam int S_OW1 = 15;
   localparam int SYNC_W = 16;
   // Read port timing
   typedef enum logic [0:0] {
      READ_SYNC = 1'b0,
      READ_ASYNC = 1'b1
   } read_mode_e;
endpackage : fifo_pkg

/* rtl/fifo_read_port_flag_control.sv */
// Notes on behaviour
// - Almost-empty high when stored words reach empty offset, else low.
// - Almost-full high while free locations exceed full offset, else low.
// - Flag timing select caught at master reset: low async, high sync.
// - Partial reset clears both pointers and the output register.
// - Partial reset keeps modes and programmed offsets.
// - Output is 72, 36 or 18 bits wide; unused lanes read zero.
// - Synchronous port reads on each read clock rise with read enable low.
// - Offset access low puts offset registers on the outputs instead.
// - Asynchronous port reads on each read strobe rise.
// - Read chip select gates reads and output drive, on read clock.
// - In reset chip select ignored; output enable low drives outputs.
// - Retransmit rewinds read pointer and shows empty; writes untouched.
// - Retransmit goes to the marked position when one is set.
// - Serial clock rise with serial enable shifts a bit into offsets.
// - Serial loading only while serial enable is asserted.
// - Mark records the read pointer as retransmit target.
// - After master reset the fall-through pin is the serial input.
// - Offset access gates offset transfers; high for normal data.
// - Fall-through or standard mode caught at master reset.
`timescale 1ns/1ps

// Storage with mark and rewind of the read pointer
module fifo_store #(
   parameter int WIDTH = 72,
   parameter int DEPTH_P = 16
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic clear_in,
   // Fill side
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   // Drain side
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in,
   // Mark and rewind
   input wire logic mark_in,
   input wire logic rewind_in,
   output logic [$clog2(DEPTH_P):0] count_out
);
   localparam int AW = $clog2(DEPTH_P);
   localparam logic [AW:0] DEPTH_V = (AW+1)'(DEPTH_P);
   logic [WIDTH-1:0] mem_q [DEPTH_P];
   logic [AW:0] wr_ptr_q;
   logic [AW:0] rd_ptr_q;
   logic [AW:0] mark_ptr_q;
   logic mark_set_q;
   wire logic push = in_valid_in & in_ready_out;
   wire logic pop = out_valid_out & out_ready_in & ~rewind_in;

   // Count above depth is possible after a rewind, so full is a compare, not equality
   assign count_out = wr_ptr_q - rd_ptr_q;
   assign in_ready_out = (count_out < DEPTH_V) & ~clear_in;
   assign out_valid_out = (count_out != '0) & ~clear_in;
   assign out_data_out = mem_q[rd_ptr_q[AW-1:0]];

   // Memory array has no reset; only pointers matter
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_q[wr_ptr_q[AW-1:0]] <= in_data_in;
      end
   end

   // Pointer and mark state
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         mark_ptr_q <= '0;
         mark_set_q <= 1'b0;
      end else if (clear_in) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         mark_ptr_q <= '0;
         mark_set_q <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (rewind_in) begin
            rd_ptr_q <= mark_set_q ? mark_ptr_q : '0;
         end else if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         if (mark_in) begin
            mark_ptr_q <= rd_ptr_q;
            mark_set_q <= 1'b1;
         end
      end
   end
endmodule : fifo_store

module fifo_read_port_flag_control
   import fifo_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // Device resets and straps
   input wire logic master_reset_n_in,
   input wire logic partial_reset_n_in,
   input wire logic flag_timing_select_in,
   input wire logic read_async_select_in,
   input wire logic [1:0] out_width_in,
   input wire logic fall_through_select_in,
   // Write side feeding the buffer
   input wire logic [DATA_W-1:0] wr_data_in,
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   // Read port pins
   input wire logic read_clk_in,
   input wire logic read_enable_n_in,
   input wire logic read_chip_select_n_in,
   input wire logic output_enable_n_in,
   input wire logic retransmit_n_in,
   input wire logic mark_in,
   input wire logic offset_access_n_in,
   // Serial offset programming
   input wire logic serial_clk_in,
   input wire logic serial_load_enable_n_in,
   // Data and flags
   output logic [DATA_W-1:0] read_data_out,
   output logic read_data_oe_out,
   output logic empty_flag_n_out,
   output logic almost_empty_flag_out,
   output logic almost_full_flag_out
);
   localparam int SHIFT_W = 2 * OFFSET_W;

   // Lanes above the selected width are forced low
   function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] width);
      logic [DATA_W-1:0] m;
      m = '1;
      if (width == WIDTH_36) begin
         m = {{(DATA_W-LANE_36){1'b0}}, {LANE_36{1'b1}}};
      end else if (width == WIDTH_18) begin
         m = {{(DATA_W-LANE_18){1'b0}}, {LANE_18{1'b1}}};
      end
      return m;
   endfunction : lane_mask

   // Pin samples, straps, offsets and output state
   logic [SYNC_W-1:0] meta_q;
   logic [SYNC_W-1:0] sync_q;
   logic rclk_d1_q;
   logic sclk_d1_q;
   logic fall_through_select_q;
   logic pfm_sync_q;
   read_mode_e read_mode_q;
   logic [1:0] width_q;
   logic [OFFSET_W-1:0] empty_offset_q;
   logic [OFFSET_W-1:0] full_offset_q;
   logic cs_q;
   logic rt_hold_q;
   logic out_valid_q;
   logic [DATA_W-1:0] out_q;
   logic ae_q;
   logic af_q;
   logic rd_upd_q;
   logic wr_upd_q;
   logic fifo_valid;
   logic [DATA_W-1:0] fifo_data;
   logic [CNT_W-1:0] count;

   // Every pin goes through two flops; the first stage feeds only the second
   wire logic [SYNC_W-1:0] pins = {out_width_in[1], out_width_in[0], read_async_select_in,
      flag_timing_select_in, partial_reset_n_in, master_reset_n_in, fall_through_select_in,
      serial_load_enable_n_in, serial_clk_in, offset_access_n_in, mark_in, retransmit_n_in,
      output_enable_n_in, read_chip_select_n_in, read_enable_n_in, read_clk_in};
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= pins;
         sync_q <= meta_q;
      end
   end

   // Decoded events
   wire logic mrs_act = ~sync_q[S_MRS_N];
   wire logic rst_act = mrs_act | ~sync_q[S_PRS_N];
   wire logic rclk_rise = sync_q[S_RCLK] & ~rclk_d1_q;
   wire logic sclk_rise = sync_q[S_SCLK] & ~sclk_d1_q;
   wire logic ld_n = sync_q[S_LD_N];
   // Same pin is clock or strobe; enable is only looked at in sync mode
   wire logic port_edge = (read_mode_q == READ_ASYNC) ? rclk_rise
      : (rclk_rise & ~sync_q[S_REN_N]);
   wire logic port_evt = port_edge & ~sync_q[S_RCS_N] & ~rst_act;
   wire logic rt_evt = rclk_rise & ~sync_q[S_RT_N] & ~rst_act;
   wire logic mark_evt = rclk_rise & sync_q[S_MARK] & ~rst_act;
   wire logic data_evt = port_evt & ld_n;
   wire logic offs_evt = port_evt & ~ld_n;
   wire logic ser_evt = sclk_rise & ~sync_q[S_SEN_N] & ~mrs_act;
   wire logic fall_through_select_load = fifo_valid & ~rt_hold_q & ~rt_evt & (~out_valid_q | data_evt);
   wire logic std_load = data_evt & fifo_valid & ~rt_hold_q & ~rt_evt;
   wire logic pop = fall_through_select_q ? fall_through_select_load : std_load;
   // Flag compares run on the live count; the flag flops decide when to look
   wire logic [CNT_W-1:0] free_cnt = DEPTH_CNT - count;
   wire logic ae_now = (count >= CNT_W'(empty_offset_q));
   wire logic af_now = (free_cnt > CNT_W'(full_offset_q));
   // Write side handshake, taken on the system clock
   wire logic push = wr_valid_in & wr_ready_out;
   // Serial shift enters at the bottom of the empty offset
   wire logic [SHIFT_W-1:0] shift_next = {full_offset_q[OFFSET_W-2:0], empty_offset_q,
      sync_q[S_SI]};
   wire logic [DATA_W-1:0] offs_word = {{(DATA_W-SHIFT_W){1'b0}}, full_offset_q, empty_offset_q};

   // Buffer clears on either device reset, so a mark never outlives one
   fifo_store #(
      .WIDTH(DATA_W),
      .DEPTH_P(DEPTH)
   ) u_store (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .clear_in(rst_act),
      .in_valid_in(wr_valid_in),
      .in_data_in(wr_data_in),
      .in_ready_out(wr_ready_out),
      .out_valid_out(fifo_valid),
      .out_data_out(fifo_data),
      .out_ready_in(pop),
      .mark_in(mark_evt),
      .rewind_in(rt_evt),
      .count_out(count)
   );

   // Edge history of the pin clocks
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rclk_d1_q <= 1'b0;
         sclk_d1_q <= 1'b0;
      end else begin
         rclk_d1_q <= sync_q[S_RCLK];
         sclk_d1_q <= sync_q[S_SCLK];
      end
   end

   // Straps follow the pins only while master reset is low
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         fall_through_select_q <= 1'b0;
         pfm_sync_q <= 1'b0;
         read_mode_q <= READ_SYNC;
         width_q <= WIDTH_72;
      end else if (mrs_act) begin
         fall_through_select_q <= sync_q[S_SI];
         pfm_sync_q <= sync_q[S_PFM];
         read_mode_q <= read_mode_e'(sync_q[S_ASYNC]);
         width_q <= {sync_q[S_OW1], sync_q[S_OW0]};
      end
   end

   // Offsets: partial reset leaves them alone so programming survives
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         empty_offset_q <= EMPTY_OFFSET_RST;
         full_offset_q <= FULL_OFFSET_RST;
      end else if (mrs_act) begin
         empty_offset_q <= EMPTY_OFFSET_RST;
         full_offset_q <= FULL_OFFSET_RST;
      end else if (ser_evt) begin
         {full_offset_q, empty_offset_q} <= shift_next;
      end
   end

   // Chip select taken on read clock edges only
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cs_q <= 1'b0;
      end else if (rclk_rise) begin
         cs_q <= ~sync_q[S_RCS_N];
      end
   end

   // Output register and retransmit hold
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         out_q <= '0;
         out_valid_q <= 1'b0;
         rt_hold_q <= 1'b0;
      end else if (rst_act) begin
         out_q <= '0;
         out_valid_q <= 1'b0;
         rt_hold_q <= 1'b0;
      end else begin
         rt_hold_q <= rt_evt;
         if (rt_evt && fall_through_select_q) begin
            out_valid_q <= 1'b0;
         end else if (offs_evt) begin
            out_q <= offs_word & lane_mask(width_q);
         end else if (pop) begin
            out_q <= fifo_data & lane_mask(width_q);
            out_valid_q <= 1'b1;
         end else if (fall_through_select_q && data_evt) begin
            out_valid_q <= 1'b0;
         end
      end
   end

   // Flags look one clock after the count moved, never at the value before it
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rd_upd_q <= 1'b0;
         wr_upd_q <= 1'b0;
      end else begin
         rd_upd_q <= pop;
         wr_upd_q <= push;
      end
   end

   // Flags: in sync timing each flag moves only on its own side's events
   // A write in sync timing leaves almost-empty stale until the next read or retransmit
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ae_q <= 1'b0;
         af_q <= 1'b1;
      end else if (rst_act) begin
         ae_q <= 1'b0;
         af_q <= 1'b1;
      end else begin
         if (!pfm_sync_q || rd_upd_q || rt_hold_q) begin
            ae_q <= ae_now;
         end
         if (!pfm_sync_q || wr_upd_q) begin
            af_q <= af_now;
         end
      end
   end

   // Outputs; drive during reset depends on output enable alone
   assign read_data_out = out_q;
   assign read_data_oe_out = ~sync_q[S_OE_N] & (rst_act | cs_q);
   assign empty_flag_n_out = fall_through_select_q ? out_valid_q : (fifo_valid & ~rt_hold_q);
   assign almost_empty_flag_out = ae_q;
   assign almost_full_flag_out = af_q;
endmodule : fifo_read_port_flag_control

/* bench/fifo_read_port_flag_control_sva.sv */
`timescale 1ns/1ps
// Pin checks; each waits out the two-flop pin sampling
module fifo_read_port_flag_control_sva
   import fifo_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // Watched pins
   input wire logic master_reset_n_in,
   input wire logic partial_reset_n_in,
   input wire logic output_enable_n_in,
   input wire logic offset_access_n_in,
   input wire logic read_clk_in,
   input wire logic [1:0] out_width_in,
   input wire logic wr_ready_out,
   input wire logic [DATA_W-1:0] read_data_out,
   input wire logic read_data_oe_out,
   input wire logic almost_empty_flag_out,
   input wire logic almost_full_flag_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   // Resets park the buffer and the flags
   mrs_park_a: assert property (!master_reset_n_in [*4] |-> !wr_ready_out && almost_full_flag_out)
      else $error("master reset did not park");
   prs_clear_a: assert property (!partial_reset_n_in [*4] |-> read_data_out == '0)
      else $error("partial reset kept data");
   prs_block_a: assert property (!partial_reset_n_in [*4] |-> !wr_ready_out && !almost_empty_flag_out)
      else $error("partial reset left buffer open");
   // Output drive
   oe_off_a: assert property (output_enable_n_in [*4] |-> !read_data_oe_out)
      else $error("pins driven with enable high");
   oe_mrs_a: assert property ((!output_enable_n_in && !master_reset_n_in) [*4] |-> read_data_oe_out)
      else $error("pins float in master reset");
   oe_prs_a: assert property ((!output_enable_n_in && !partial_reset_n_in) [*4] |-> read_data_oe_out)
      else $error("pins float in partial reset");
   // A full buffer has no free location above any offset
   full_flag_a: assert property ((master_reset_n_in && partial_reset_n_in) [*4] ##1 !wr_ready_out
      |-> ##1 !almost_full_flag_out)
      else $error("almost full high when full");
   lane_mask_a: assert property ((out_width_in == WIDTH_18) [*4] |-> (read_data_out >> LANE_18) == '0)
      else $error("upper lanes not blank");
   cover property (!offset_access_n_in && $rose(read_clk_in));
   cover property (master_reset_n_in && !wr_ready_out);
   cover property (!partial_reset_n_in ##1 partial_reset_n_in);
endmodule : fifo_read_port_flag_control_sva

/* bench/ctrl_model.sv */
`timescale 1ns/1ps
// Outside controller: read port strokes and serial offset loading
module ctrl_model (
   // Clock
   input wire logic clk_in,
   // Read port pins
   output logic rclk_out,
   output logic ren_n_out,
   output logic rcs_n_out,
   output logic rt_n_out,
   output logic mark_out,
   output logic ld_n_out,
   // Serial pins
   output logic sclk_out,
   output logic sen_n_out,
   output logic si_out
);
   // Idle levels; both clocks stand still between transfers
   initial {rclk_out, ren_n_out, rcs_n_out, rt_n_out, mark_out, ld_n_out} = 6'h15;
   initial {sclk_out, sen_n_out, si_out} = 3'h2;
   // Levels last 4 clocks because the device samples the pins
   task automatic pulse(input logic [3:0] p);
      @(negedge clk_in);
      {ren_n_out, rt_n_out, mark_out, ld_n_out} = p;
      repeat (4) @(negedge clk_in);
      rclk_out = 1;
      repeat (4) @(negedge clk_in);
      rclk_out = 0;
      repeat (4) @(negedge clk_in);
      // Read enable keeps its level so a strobe-mode host can hold it low
      {rt_n_out, mark_out, ld_n_out} = 3'h5;
   endtask : pulse
   // Ten bits, first one ends at the top of the full offset
   task automatic shift(input logic [9:0] v);
      sen_n_out = 0;
      for (int i = 9; i >= 0; i--) begin
         @(negedge clk_in);
         si_out = v[i];
         repeat (4) @(negedge clk_in);
         sclk_out = 1;
         repeat (4) @(negedge clk_in);
         sclk_out = 0;
      end
      repeat (4) @(negedge clk_in);
      sen_n_out = 1;
      si_out = ~si_out; // No stale bit once released
   endtask : shift
endmodule : ctrl_model

/* bench/tb_fifo_read_port_flag_control.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
   $display("Error %0t %h %h", $time, (a), (b)); end end
module tb_fifo_read_port_flag_control;
   import fifo_pkg::*;
   typedef struct packed {
      logic [DATA_W-1:0] d;
      logic [1:0] fl;
   } row_s;
   row_s rows [DEPTH];
   logic clk_in, reset_n_in, mrs_n, prs_n, wv, oe_n, afs, flag_timing_select;
   logic [1:0] ow;
   logic [DATA_W-1:0] wd;
   wire logic rclk, ren_n, rcs_n, rt_n, mk, ld_n, sclk, sen_n, si, wrdy, oe, efn, ae, af;
   wire logic [DATA_W-1:0] q;
   int n_mismatch = 0, checked = 0;
   // 50 MHz clock
   initial begin
      clk_in = 0;
      forever #10 clk_in = ~clk_in;
   end
   ctrl_model ctrl_model_inst (.clk_in, .rclk_out(rclk), .ren_n_out(ren_n), .rcs_n_out(rcs_n),
      .rt_n_out(rt_n), .mark_out(mk), .ld_n_out(ld_n), .sclk_out(sclk), .sen_n_out(sen_n),
      .si_out(si));
   fifo_read_port_flag_control fifo_read_port_flag_control_inst (.clk_in, .reset_n_in,
      .master_reset_n_in(mrs_n), .partial_reset_n_in(prs_n), .flag_timing_select_in(flag_timing_select),
      .read_async_select_in(afs), .out_width_in(ow), .fall_through_select_in(si),
      .wr_data_in(wd), .wr_valid_in(wv), .wr_ready_out(wrdy), .read_clk_in(rclk),
      .read_enable_n_in(ren_n), .read_chip_select_n_in(rcs_n), .output_enable_n_in(oe_n),
      .retransmit_n_in(rt_n), .mark_in(mk), .offset_access_n_in(ld_n), .serial_clk_in(sclk),
      .serial_load_enable_n_in(sen_n), .read_data_out(q), .read_data_oe_out(oe),
      .empty_flag_n_out(efn), .almost_empty_flag_out(ae), .almost_full_flag_out(af));
   // One write, then one clock for the flags to follow
   task automatic wr(input logic [DATA_W-1:0] d);
      @(negedge clk_in);
      wd = d;
      wv = 1;
      @(negedge clk_in);
      wv = 0;
      @(negedge clk_in);
   endtask : wr
   // Master (m high) or partial reset, held long past pin sampling
   task automatic rst(input logic m, input logic [1:0] w);
      @(negedge clk_in);
      ow = w;
      mrs_n = !m;
      prs_n = m;
      repeat (5) @(negedge clk_in);
      {mrs_n, prs_n} = 2'h3;
      repeat (5) @(negedge clk_in);
   endtask : rst
   task automatic summarize;
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize
   // Run needs under 2000 clocks
   initial begin
      #100us;
      n_mismatch++;
      summarize();
   end
   // Strokes: 5 read, f mark, 9 retransmit, 4 offset read, d idle
   initial begin
      {reset_n_in, mrs_n, prs_n, wv, oe_n, afs, flag_timing_select, ow, wd} = '0;
      foreach (rows[i]) rows[i] = {{8{9'(i + 1)}}, i + 1 >= EMPTY_OFFSET_RST,
         DEPTH - i - 1 > FULL_OFFSET_RST};
      repeat (3) @(negedge clk_in);
      reset_n_in = 1;
      rst(1, WIDTH_72);
      `CHK({wrdy, ae, af, efn}, 4'ha)
      // Fill until the buffer refuses
      foreach (rows[i]) begin
         wr(rows[i].d);
         `CHK({ae, af}, rows[i].fl)
      end
      `CHK(wrdy, 1'b0)
      for (int i = 0; i < 3; i++) begin
         ctrl_model_inst.pulse(4'h5);
         `CHK(q, rows[i].d)
      end
      `CHK({oe, af}, 2'h3)
      // Mark word 3, read on, rewind to the mark
      ctrl_model_inst.pulse(4'hf);
      ctrl_model_inst.pulse(4'h5);
      ctrl_model_inst.pulse(4'h5);
      `CHK(q, rows[4].d)
      ctrl_model_inst.pulse(4'h9);
      ctrl_model_inst.pulse(4'h5);
      `CHK(q, rows[3].d)
      // Deselected read is refused and the pins float
      ctrl_model_inst.rcs_n_out = 1;
      ctrl_model_inst.pulse(4'h5);
      `CHK({oe, q}, {1'b0, rows[3].d})
      ctrl_model_inst.rcs_n_out = 0;
      ctrl_model_inst.pulse(4'hd);
      `CHK(oe, 1'b1)
      oe_n = 1;
      repeat (5) @(negedge clk_in);
      `CHK(oe, 1'b0)
      oe_n = 0;
      ctrl_model_inst.shift(10'h0e3);
      ctrl_model_inst.pulse(4'h4);
      `CHK(q, 72'h0e3)
      // Partial reset keeps the new empty offset of 3
      rst(0, WIDTH_72);
      `CHK({q, ae, af}, {72'h0, 2'h1})
      wr(rows[0].d);
      wr(rows[1].d);
      `CHK(ae, 1'b0)
      wr(rows[2].d);
      `CHK(ae, 1'b1)
      ctrl_model_inst.pulse(4'h5);
      `CHK(q, rows[0].d)
      ctrl_model_inst.pulse(4'h4);
      `CHK(q, 72'h0e3)
      for (int k = 1; k < 3; k++) begin
         rst(1, 2'(k));
         wr(rows[8].d);
         ctrl_model_inst.pulse(4'h5);
         `CHK(q, rows[8].d & ~({DATA_W{1'b1}} << (k == 1 ? LANE_36 : LANE_18)))
      end
      // Strobe read port with synchronous flag timing
      {afs, flag_timing_select} = 2'h3;
      ctrl_model_inst.ren_n_out = 0;
      rst(1, WIDTH_72);
      for (int i = 0; i < DEPTH - FULL_OFFSET_RST; i++) begin
         wr(rows[i].d);
      end
      `CHK({ae, af}, 2'h0)
      ctrl_model_inst.pulse(4'h5);
      `CHK({q, ae, af}, {rows[0].d, 2'h2})
      {afs, flag_timing_select} = 2'h0;
      // Fall-through: first word shows without a read
      ctrl_model_inst.si_out = 1;
      rst(1, WIDTH_72);
      wr(rows[9].d);
      repeat (2) @(negedge clk_in);
      `CHK({efn, q}, {1'b1, rows[9].d})
      summarize();
   end
endmodule : tb_fifo_read_port_flag_control
bind fifo_read_port_flag_control fifo_read_port_flag_control_sva fifo_read_port_flag_control_sva_inst (
   .clk_in, .reset_n_in, .master_reset_n_in, .partial_reset_n_in, .output_enable_n_in,
   .offset_access_n_in, .read_clk_in, .out_width_in, .wr_ready_out, .read_data_out,
   .read_data_oe_out, .almost_empty_flag_out, .almost_full_flag_out);
